// ---- pkg/itc_consts.vh ----
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH

// master clock period, in picoseconds (66.6 ns)
`define ITC_MASTER_PERIOD_PS 36'h0_0001_0428

// operation classes
`define ITC_OP_GENERIC 4'h0
`define ITC_OP_SHIFT_LEFT_ARITH 4'h1
`define ITC_OP_SHIFT_RIGHT_ARITH 4'h2
`define ITC_OP_ROTATE_RIGHT 4'h3
`define ITC_OP_SHIFT_RIGHT_LOGICAL 4'h4
`define ITC_OP_SERIAL_IO_LOAD 4'h5
`define ITC_OP_SERIAL_IO_STORE 4'h6
`define ITC_OP_WORD_MOVE 4'h7
`define ITC_OP_BYTE_MOVE 4'h8
`define ITC_OP_DIVIDE 4'h9
`define ITC_OP_FLOAT_SINGLE 4'hA
`define ITC_OP_FLOAT_DOUBLE 4'hB

// base cycle figures
`define ITC_SHIFT_BASE 12'h00E
`define ITC_SHIFT_ZERO_BASE 12'h045
`define ITC_SHIFT_PER_POS 12'h003
`define ITC_LOAD_IO_BASE 12'h00F
`define ITC_LOAD_IO_PER_BIT 12'h018
`define ITC_STORE_IO_ZERO_BASE 12'h0B8
`define ITC_STORE_IO_LOW_BASE 12'h051
`define ITC_STORE_IO_HIGH_BASE 12'h048
`define ITC_STORE_IO_LOW_PER_BIT 12'h004
`define ITC_STORE_IO_HIGH_PER_BIT 12'h00E
`define ITC_STORE_IO_LOW_MAX 4'h7
`define ITC_WORD_MOVE_BASE 12'h007
`define ITC_BYTE_MOVE_BASE 12'h00A
`define ITC_DIVIDE_BASE 12'h050

// mantissa widths
`define ITC_MANT_SINGLE 6'h18
`define ITC_MANT_DOUBLE 6'h38

// memory regions
`define ITC_REGION_P 2'h0
`define ITC_REGION_W 2'h1
`define ITC_REGION_G 2'h2

// sequencer states, one-hot
`define ITC_S_IDLE 5'h01
`define ITC_S_BASE 5'h02
`define ITC_S_ACC 5'h04
`define ITC_S_WAIT 5'h08
`define ITC_S_DONE 5'h10

`endif

// ---- hw/itc_wait.v ----
`timescale 1ns/1ns
`include "itc_consts.vh"

module itc_wait (
   input wire clock,
   input wire rst_b,
   input wire go,
   input wire [3:0] delay,
   input wire dynamic,
   input wire ready,
   output wire stretch,
   output wire finish
);

reg active;
reg [3:0] left;

// dynamic memory ends on ready, static memory on its fixed count
assign finish = active & (dynamic ? ready : (left == 4'h0));
assign stretch = active & ~finish;

// count down the delay or wait for ready
always @(posedge clock or negedge rst_b) begin
   if (!rst_b) begin
      active <= 1'b0;
      left <= 4'h0;
   end else if (go) begin
      active <= 1'b1;
      left <= delay;
   end else if (finish) begin
      active <= 1'b0;
   end else if (active && !dynamic) begin
      left <= left - 4'h1;
   end
end

endmodule // itc_wait

// ---- hw/itc_timer.v ----
`timescale 1ns/1ns
`include "itc_consts.vh"

module itc_timer (
   input wire clock,
   input wire rst_b,
   input wire start,
   input wire [3:0] op,
   input wire [3:0] count,
   input wire [11:0] base_in,
   input wire [3:0] p_accesses,
   input wire [3:0] w_accesses,
   input wire [3:0] g_accesses,
   input wire [3:0] p_delay,
   input wire [3:0] w_delay,
   input wire [3:0] g_delay,
   input wire p_dynamic,
   input wire w_dynamic,
   input wire g_dynamic,
   input wire bus_ready,
   output reg busy,
   output reg done,
   output reg [15:0] total_cycles,
   output reg [35:0] exec_time_ps,
   output reg mem_req,
   output reg [1:0] mem_region,
   output reg fetch_dest,
   output reg [5:0] mantissa_width
);

// one-hot sequencer states
localparam [4:0] ST_IDLE = `ITC_S_IDLE;
localparam [4:0] ST_BASE = `ITC_S_BASE;
localparam [4:0] ST_ACC = `ITC_S_ACC;
localparam [4:0] ST_WAIT = `ITC_S_WAIT;
localparam [4:0] ST_DONE = `ITC_S_DONE;

reg [4:0] state;
reg [11:0] base_left;
reg [15:0] total;
reg [4:0] rem_p;
reg [4:0] rem_w;
reg [4:0] rem_g;
reg ready_meta;
reg ready_sync;

reg [11:0] next_base;
reg [4:0] next_rem_w;
reg [4:0] next_rem_g;
reg next_fetch_dest;
reg [5:0] next_mantissa;
reg [3:0] cur_delay;
reg cur_dynamic;
reg [4:0] cur_rem;

wire [11:0] count12;
wire [11:0] shift_extra;
wire [11:0] load_extra;
wire [11:0] store_low_extra;
wire [11:0] store_high_extra;
wire wait_stretch;
wire wait_finish;

assign count12 = {8'h00, count};
assign shift_extra = count12 * `ITC_SHIFT_PER_POS;
assign load_extra = count12 * `ITC_LOAD_IO_PER_BIT;
assign store_low_extra = count12 * `ITC_STORE_IO_LOW_PER_BIT;
assign store_high_extra = count12 * `ITC_STORE_IO_HIGH_PER_BIT;

// bus ready is a pin from the memory boards, so it is synchronised
always @(posedge clock or negedge rst_b) begin
   if (!rst_b) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
   end else begin
      ready_meta <= bus_ready;
      ready_sync <= ready_meta;
   end
end

// base cycles and charged accesses for the requested instruction
always @* begin
   next_base = base_in;
   next_rem_w = {1'b0, w_accesses};
   next_rem_g = {1'b0, g_accesses};
   next_fetch_dest = 1'b0;
   next_mantissa = 6'h00;
   case (op)
      `ITC_OP_SHIFT_LEFT_ARITH,
      `ITC_OP_SHIFT_RIGHT_ARITH,
      `ITC_OP_ROTATE_RIGHT,
      `ITC_OP_SHIFT_RIGHT_LOGICAL: begin
         // a zero count means the count comes from a register
         if (count == 4'h0) begin
            next_base = `ITC_SHIFT_ZERO_BASE;
         end else begin
            next_base = `ITC_SHIFT_BASE + shift_extra;
         end
      end
      `ITC_OP_SERIAL_IO_LOAD: begin
         next_base = `ITC_LOAD_IO_BASE + load_extra;
      end
      `ITC_OP_SERIAL_IO_STORE: begin
         // zero count transfers the full sixteen bits
         if (count == 4'h0) begin
            next_base = `ITC_STORE_IO_ZERO_BASE;
         end else if (count <= `ITC_STORE_IO_LOW_MAX) begin
            next_base = `ITC_STORE_IO_LOW_BASE + store_low_extra;
         end else begin
            next_base = `ITC_STORE_IO_HIGH_BASE + store_high_extra;
         end
      end
      `ITC_OP_WORD_MOVE: begin
         next_base = `ITC_WORD_MOVE_BASE;
      end
      `ITC_OP_BYTE_MOVE: begin
         // the old destination byte must be read before merging
         next_base = `ITC_BYTE_MOVE_BASE;
         next_rem_g = {1'b0, g_accesses} + 5'h01;
         next_fetch_dest = 1'b1;
      end
      `ITC_OP_DIVIDE: begin
         next_base = `ITC_DIVIDE_BASE;
      end
      `ITC_OP_FLOAT_SINGLE,
      `ITC_OP_FLOAT_DOUBLE: begin
         // operand fetch delays already sit in the base figure
         next_rem_w = 5'h00;
         next_rem_g = 5'h00;
         if (op == `ITC_OP_FLOAT_DOUBLE) begin
            next_mantissa = `ITC_MANT_DOUBLE;
         end else begin
            next_mantissa = `ITC_MANT_SINGLE;
         end
      end
      default: begin
         next_base = base_in;
      end
   endcase
end

// per-region delay figure for the access in progress
always @* begin
   case (mem_region)
      `ITC_REGION_P: begin
         cur_delay = p_delay;
         cur_dynamic = p_dynamic;
         cur_rem = rem_p;
      end
      `ITC_REGION_W: begin
         cur_delay = w_delay;
         cur_dynamic = w_dynamic;
         cur_rem = rem_w;
      end
      default: begin
         cur_delay = g_delay;
         cur_dynamic = g_dynamic;
         cur_rem = rem_g;
      end
   endcase
end

// stretches one access by a fixed count or until ready
itc_wait u_wait (
   .clock(clock),
   .rst_b(rst_b),
   .go(mem_req),
   .delay(cur_delay),
   .dynamic(cur_dynamic),
   .ready(ready_sync),
   .stretch(wait_stretch),
   .finish(wait_finish)
);

// sequencer: base cycles first, then P, W and G accesses in turn
always @(posedge clock or negedge rst_b) begin
   if (!rst_b) begin
      state <= ST_IDLE;
      base_left <= 12'h000;
      total <= 16'h0000;
      rem_p <= 5'h00;
      rem_w <= 5'h00;
      rem_g <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      total_cycles <= 16'h0000;
      exec_time_ps <= 36'h0_0000_0000;
      mem_req <= 1'b0;
      mem_region <= `ITC_REGION_P;
      fetch_dest <= 1'b0;
      mantissa_width <= 6'h00;
   end else begin
      done <= 1'b0;
      mem_req <= 1'b0;
      case (state)
         ST_IDLE: begin
            // a start while busy is ignored
            if (start) begin
               busy <= 1'b1;
               total <= 16'h0000;
               base_left <= next_base;
               rem_p <= {1'b0, p_accesses};
               rem_w <= next_rem_w;
               rem_g <= next_rem_g;
               fetch_dest <= next_fetch_dest;
               mantissa_width <= next_mantissa;
               mem_region <= `ITC_REGION_P;
               if (next_base == 12'h000) begin
                  state <= ST_ACC;
               end else begin
                  state <= ST_BASE;
               end
            end
         end
         ST_BASE: begin
            // one master period counted per base cycle
            total <= total + 16'h0001;
            base_left <= base_left - 12'h001;
            if (base_left == 12'h001) begin
               state <= ST_ACC;
            end
         end
         ST_ACC: begin
            if (cur_rem != 5'h00) begin
               mem_req <= 1'b1;
               state <= ST_WAIT;
            end else if (mem_region == `ITC_REGION_G) begin
               state <= ST_DONE;
            end else begin
               mem_region <= mem_region + 2'h1;
            end
         end
         ST_WAIT: begin
            // delays accumulate access by access
            if (wait_stretch) begin
               total <= total + 16'h0001;
            end
            if (wait_finish) begin
               state <= ST_ACC;
               case (mem_region)
                  `ITC_REGION_P: rem_p <= rem_p - 5'h01;
                  `ITC_REGION_W: rem_w <= rem_w - 5'h01;
                  default: rem_g <= rem_g - 5'h01;
               endcase
            end
         end
         ST_DONE: begin
            // time is a whole multiple of the master period
            total_cycles <= total;
            exec_time_ps <= {20'h0_0000, total} * `ITC_MASTER_PERIOD_PS;
            done <= 1'b1;
            busy <= 1'b0;
            state <= ST_IDLE;
         end
         default: begin
            state <= ST_IDLE;
         end
      endcase
   end
end

endmodule // itc_timer

// ---- bench/itc_mem_model.sv ----
`timescale 1ns/1ns
module itc_mem_model (
   input wire clock,
   input wire rst_b,
   input wire mem_req,
   input wire [3:0] stall,
   output reg bus_ready
);
   reg [4:0] left;
   // ready idles low and pulses once; a refresh stall delays it by stall cycles
   // a single pulse keeps a stale ready from ending the next access early
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         left <= 5'h00;
         bus_ready <= 1'b0;
      end else if (mem_req) begin
         left <= {1'b0, stall} + 5'h01;
         bus_ready <= 1'b0;
      end else begin
         left <= (left != 5'h00) ? left - 5'h01 : 5'h00;
         bus_ready <= (left == 5'h01);
      end
   end
endmodule // itc_mem_model

// ---- bench/itc_timer_monitor.sv ----
`timescale 1ns/1ns
module itc_monitor (
   input wire clock,
   input wire rst_b,
   input wire start,
   input wire [3:0] op,
   input wire [3:0] count,
   input wire busy,
   input wire done,
   input wire [15:0] total_cycles,
   input wire [35:0] exec_time_ps,
   input wire mem_req,
   input wire fetch_dest,
   input wire [5:0] mantissa_width
);
   reg [3:0] op_q;
   reg [3:0] cnt_q;
   reg [15:0] run_len;
   // op may change while busy, so keep the accepted request
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         op_q <= 4'h0;
         cnt_q <= 4'h0;
         run_len <= 16'h0000;
      end else if (start && !busy) begin
         op_q <= op;
         cnt_q <= count;
         run_len <= 16'h0000;
      end else if (busy) begin
         run_len <= run_len + 16'h0001;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_accept;
      start && !busy;
   endsequence
   sequence s_finish;
      done && !busy;
   endsequence
   a_busy_rises: assert property (s_accept |=> busy)
      else $error("busy did not rise");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_idle: assert property (done |-> s_finish)
      else $error("busy high with done");
   a_time_ps: assert property (done |-> exec_time_ps == total_cycles * 36'h0_0001_0428)
      else $error("time not cycles times period");
   a_shift_base: assert property (s_finish ##0 (op_q >= 4'h1 && op_q <= 4'h4 && cnt_q != 4'h0)
      |-> total_cycles >= 16'h000E + 16'h0003 * cnt_q)
      else $error("shift total too small");
   a_load_base: assert property (done && op_q == 4'h5
      |-> total_cycles >= 16'h000F + 16'h0018 * cnt_q)
      else $error("serial load total too small");
   a_divide_base: assert property (done && op_q == 4'h9 |-> total_cycles >= 16'h0050)
      else $error("divide total too small");
   a_fetch_dest: assert property (done |-> fetch_dest == (op_q == 4'h8))
      else $error("destination fetch wrong");
   a_mant_width: assert property (done |-> mantissa_width
      == (op_q == 4'hA ? 6'h18 : op_q == 4'hB ? 6'h38 : 6'h00))
      else $error("mantissa width wrong");
   a_run_len: assert property (done |-> run_len > total_cycles)
      else $error("charged more cycles than ran");
   a_req_busy: assert property (mem_req |-> busy)
      else $error("access while idle");
endmodule // itc_monitor
bind itc_timer itc_monitor mon_u (.clock(clock), .rst_b(rst_b), .start(start), .op(op),
   .count(count), .busy(busy), .done(done), .total_cycles(total_cycles),
   .exec_time_ps(exec_time_ps), .mem_req(mem_req), .fetch_dest(fetch_dest),
   .mantissa_width(mantissa_width));

// ---- bench/itc_timer_test.sv ----
`timescale 1ns/1ns
`define CHK(a, b) cmp(a, b)
module itc_timer_test;
   reg clock;
   reg rst_b;
   reg start;
   reg [3:0] op, count, pa, wa, ga, pd, wd, gd, stall;
   reg [11:0] base_in;
   reg [2:0] dyn;
   reg [15:0] e;
   reg [31:0] r;
   wire bus_ready, busy, done, mem_req, fetch_dest;
   wire [15:0] total_cycles;
   wire [35:0] exec_time_ps;
   wire [1:0] mem_region;
   wire [5:0] mantissa_width;
   integer n_mismatch, checked, i, j, seed;
   itc_timer dut_u (.clock(clock), .rst_b(rst_b), .start(start), .op(op), .count(count),
      .base_in(base_in), .p_accesses(pa), .w_accesses(wa), .g_accesses(ga),
      .p_delay(pd), .w_delay(wd), .g_delay(gd), .p_dynamic(dyn[0]), .w_dynamic(dyn[1]),
      .g_dynamic(dyn[2]), .bus_ready(bus_ready), .busy(busy), .done(done),
      .total_cycles(total_cycles), .exec_time_ps(exec_time_ps), .mem_req(mem_req),
      .mem_region(mem_region), .fetch_dest(fetch_dest), .mantissa_width(mantissa_width));
   itc_mem_model mem_u (.clock(clock), .rst_b(rst_b), .mem_req(mem_req), .stall(stall),
      .bus_ready(bus_ready));
   always #20 clock = ~clock;
   task cmp(input [35:0] g, input [35:0] x);
      begin
         checked = checked + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
         end
      end
   endtask
   // static-memory total: base figure plus accesses times delay per region
   function [15:0] exp_total(input [3:0] o, input [3:0] c, input [11:0] b);
      reg [15:0] t;
      begin
         case (o)
            4'h1, 4'h2, 4'h3, 4'h4: t = (c == 4'h0) ? 16'h0045 : 16'h000E + 16'h0003 * c;
            4'h5: t = 16'h000F + 16'h0018 * c;
            4'h6: t = (c == 4'h0) ? 16'h00B8 : (c < 4'h8) ? 16'h0051 + 16'h0004 * c
               : 16'h0048 + 16'h000E * c;
            4'h7: t = 16'h0007;
            4'h8: t = 16'h000A;
            4'h9: t = 16'h0050;
            default: t = {4'h0, b};
         endcase
         t = t + pa * pd;
         // float operand fetch waits are already inside the base figure
         if (o < 4'hA)
            t = t + wa * wd + (ga + (o == 4'h8)) * gd;
         exp_total = t;
      end
   endfunction
   task conclude;
      begin
         $display("mismatches=%0d comparisons=%0d", n_mismatch, checked);
         if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // start held over a second edge with another op: that edge falls while busy
   task go(input [3:0] o, input [3:0] c, input [11:0] b);
      begin
         @(negedge clock);
         op = o;
         count = c;
         base_in = b;
         start = 1'b1;
         e = exp_total(o, c, b);
         @(negedge clock);
         op = ~o;
         @(negedge clock);
         start = 1'b0;
         i = 0;
         while (done !== 1'b1 && i < 4000) begin
            @(negedge clock);
            i = i + 1;
         end
         // a done seen on the last allowed cycle is not a timeout
         if (done !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            conclude;
         end else begin
            if (dyn == 3'h0)
               `CHK(total_cycles, e);
            else
               `CHK(total_cycles + 16'h0001 >= e + stall && total_cycles <= e + 4 + stall, 1);
            `CHK(exec_time_ps, e * 36'h0_0001_0428 + (total_cycles - e) * 36'h0_0001_0428);
            `CHK(fetch_dest, o == 4'h8);
            `CHK(mantissa_width, o == 4'hA ? 6'h18 : o == 4'hB ? 6'h38 : 6'h00);
            `CHK(mem_region, 2'h2);
            @(negedge clock);
            `CHK(done, 1'b0);
         end
      end
   endtask
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      start = 1'b0;
      base_in = 12'h000;
      dyn = 3'h0;
      {op, count, pa, wa, ga, pd, wd, gd, stall} = 36'h0_0000_0000;
      n_mismatch = 0;
      checked = 0;
      seed = $urandom(32'hA1A8);
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst_b = 1'b1;
      // arithmetic right shift by four, one slow static program access
      {pa, wa, ga, pd, wd, gd} = 24'h100600;
      go(4'h2, 4'h4, 12'h000);
      // divide with mixed region speeds
      {pa, wa, ga, pd, wd, gd} = 24'h140630;
      go(4'h9, 4'h0, 12'h000);
      // every op class at count boundaries 0, 7, 8 and 15
      {pa, wa, ga, pd, wd, gd} = 24'h121632;
      for (j = 0; j < 48; j = j + 1)
         go(j[5:2], (16'hF870 >> {j[1:0], 2'b00}) & 4'hF, 12'h005);
      for (j = 0; j < 40; j = j + 1) begin
         r = $urandom;
         {pa, wa, ga, pd, wd, gd} = r[23:0] & 24'h333777;
         go(r[27:24] % 4'hC, r[31:28], {4'h0, r[7:0] ^ r[15:8]});
      end
      // dynamic memory per region, prompt then held off by refresh
      {pa, wa, ga, pd, wd, gd} = 24'h111000;
      for (j = 0; j < 6; j = j + 1) begin
         dyn = 3'h1 << (j % 3);
         stall = (j < 3) ? 4'h0 : 4'h6;
         go(4'h9, 4'h0, 12'h000);
      end
      dyn = 3'h0;
      conclude;
   end
endmodule // itc_timer_test
